// *** rfc_pkg.sv ***
package rfc_pkg;
  localparam logic [6:0] RFC_ADDR_RX_FUNC = 7'h08;
  localparam logic [6:0] RFC_ADDR_XTAL_LOAD = 7'h09;
  localparam int RFC_ANT_MSB = 7;
  localparam int RFC_ANT_LSB = 5;
  localparam int RFC_MPK_BIT = 4;
  localparam int RFC_LDM_BIT = 2;
  localparam int RFC_FCLR_BIT = 1;
  localparam int RFC_SHFT_BIT = 7;
  localparam logic [7:0] RFC_RX_FUNC_RST = 8'h00;
  localparam logic [7:0] RFC_XTAL_LOAD_RST = 8'h00;
  localparam logic [7:0] RFC_RX_FUNC_WMASK = 8'hF6;
  typedef enum logic [1:0] {
    RFC_CLR_IDLE = 2'b00,
    RFC_CLR_ARMED = 2'b01
  } rfc_clr_e;
endpackage : rfc_pkg

// *** rfc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Codes 000-011 drive fixed antenna levels.
// - Codes 100-111 hand receive control to diversity.
// - Multi-packet bit keeps receive on after packets.
// - Low-duty enable turns receiver on periodically.
// - Clear bit written 1 then 0 empties FIFO.
// - Seven-bit crystal load code in bits 6:0.
// - Coarse shift bit is separate, not ordered.
// - Valid packet clears manual receive-on if single.
module rfc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_state,
  input wire logic pkt_valid,
  input wire logic div_ant_a,
  input wire logic div_ant_b,
  output logic antenna_select_out_a,
  output logic antenna_select_out_b,
  output logic fifo_mode_multi_pkt,
  output logic rx_leave_req,
  output logic rxon_auto_clr,
  output logic low_duty_enable,
  output logic div_enable,
  output logic div_beacon_mode,
  output logic rx_fifo_clear,
  output logic [6:0] xtal_load_code,
  output logic xtal_coarse_shift
);
  import rfc_pkg::*;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [7:0] rx_func_r;
  logic [7:0] xtal_load_r;
  logic [7:0] rdata_nxt;
  rfc_clr_e clr_r;
  logic fifo_clr_r;
  logic ant_a_nxt;
  logic ant_b_nxt;
  logic [2:0] ant_sel;
  logic wr_func;

  assign wr_func = reg_wr_en && (reg_addr == RFC_ADDR_RX_FUNC);
  assign ant_sel = rx_func_r[RFC_ANT_MSB:RFC_ANT_LSB];

  // Reserved bits 3 and 0 are not stored and read back as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_func_r <= RFC_RX_FUNC_RST;
    end else if (wr_func) begin
      rx_func_r <= reg_wdata & RFC_RX_FUNC_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_load_r <= RFC_XTAL_LOAD_RST;
    end else if (reg_wr_en && (reg_addr == RFC_ADDR_XTAL_LOAD)) begin
      xtal_load_r <= reg_wdata;
    end
  end

  // A lone write of 1 does nothing; the clear fires on the later write of 0.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_r <= RFC_CLR_IDLE;
      fifo_clr_r <= 1'b0;
    end else begin
      fifo_clr_r <= 1'b0;
      case (clr_r)
        RFC_CLR_IDLE: begin
          if (wr_func && reg_wdata[RFC_FCLR_BIT]) begin
            clr_r <= RFC_CLR_ARMED;
          end
        end
        RFC_CLR_ARMED: begin
          if (wr_func && !reg_wdata[RFC_FCLR_BIT]) begin
            clr_r <= RFC_CLR_IDLE;
            fifo_clr_r <= 1'b1;
          end
        end
        default: clr_r <= RFC_CLR_IDLE;
      endcase
    end
  end

  always_comb begin
    if (rx_state) begin
      case (ant_sel)
        3'h0, 3'h2: begin
          ant_a_nxt = 1'b0;
          ant_b_nxt = 1'b1;
        end
        3'h1, 3'h3: begin
          ant_a_nxt = 1'b1;
          ant_b_nxt = 1'b0;
        end
        default: begin
          ant_a_nxt = div_ant_a;
          ant_b_nxt = div_ant_b;
        end
      endcase
    end else if (ant_sel[2]) begin
      ant_a_nxt = ant_sel[0];
      ant_b_nxt = ant_sel[0];
    end else begin
      ant_a_nxt = ant_sel[1];
      ant_b_nxt = ant_sel[1];
    end
  end

  // Combinational so the pins change in the cycle receive state changes.
  assign antenna_select_out_a = ant_a_nxt;
  assign antenna_select_out_b = ant_b_nxt;

  assign div_enable = rx_state && ant_sel[2];
  assign div_beacon_mode = ant_sel[2] && ant_sel[1];
  assign fifo_mode_multi_pkt = rx_func_r[RFC_MPK_BIT];
  assign rx_leave_req = pkt_valid && !rx_func_r[RFC_MPK_BIT];
  assign rxon_auto_clr = pkt_valid && !rx_func_r[RFC_MPK_BIT];
  assign low_duty_enable = rx_func_r[RFC_LDM_BIT];
  assign rx_fifo_clear = fifo_clr_r;
  // The coarse bit leaves as its own signal, never merged with the code.
  assign xtal_load_code = xtal_load_r[6:0];
  assign xtal_coarse_shift = xtal_load_r[RFC_SHFT_BIT];

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_en) begin
      case (reg_addr)
        RFC_ADDR_RX_FUNC: rdata_nxt = rx_func_r;
        RFC_ADDR_XTAL_LOAD: rdata_nxt = xtal_load_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // The clear is checked in two bounded steps, arming and then firing,
  // so no check has to span the open-ended gap between the two writes.
  sequence s_clr_set;
    wr_func && reg_wdata[RFC_FCLR_BIT] && clr_r == RFC_CLR_IDLE;
  endsequence

  sequence s_clr_back;
    wr_func && !reg_wdata[RFC_FCLR_BIT] && clr_r == RFC_CLR_ARMED;
  endsequence

  chk_clear_arms: assert property (
    s_clr_set |=> clr_r == RFC_CLR_ARMED)
    else $error("Set write did not arm the FIFO clear");
  chk_fifo_clear_seq: assert property (
    s_clr_back |=> rx_fifo_clear)
    else $error("FIFO clear missing after set then clear writes");
  chk_clear_needs_arm: assert property (
    rx_fifo_clear |-> $past(clr_r) == RFC_CLR_ARMED)
    else $error("FIFO clear without prior set write");
  chk_clear_after_write: assert property (
    rx_fifo_clear |-> $past(wr_func))
    else $error("FIFO clear without a register write");
  chk_clear_pulse: assert property (
    rx_fifo_clear |=> !rx_fifo_clear)
    else $error("FIFO clear lasted more than one cycle");
  chk_fixed_rx_ant: assert property (
    rx_state && !ant_sel[2] |-> antenna_select_out_a == ant_sel[0]
      && antenna_select_out_b == !ant_sel[0])
    else $error("Fixed antenna levels wrong in receive");
  chk_fixed_idle_ant: assert property (
    !rx_state && !ant_sel[2] |-> antenna_select_out_a == ant_sel[1]
      && antenna_select_out_b == ant_sel[1])
    else $error("Fixed antenna levels wrong outside receive");
  // Receive entry and exit must move pin b in that very cycle for fixed codes.
  chk_ant_rx_edge: assert property (
    $changed(rx_state) && !ant_sel[2] |-> antenna_select_out_b
      == (rx_state ? !ant_sel[0] : ant_sel[1]))
    else $error("Antenna pins lag the receive state change");
  chk_div_ant: assert property (
    rx_state && ant_sel[2] |-> antenna_select_out_a == div_ant_a
      && antenna_select_out_b == div_ant_b)
    else $error("Diversity not driving antennas in receive");
  chk_div_idle: assert property (
    !rx_state && ant_sel[2] |-> antenna_select_out_a == ant_sel[0])
    else $error("Idle diversity antenna level wrong");
  chk_div_idle_b: assert property (
    !rx_state && ant_sel[2] |-> antenna_select_out_b == ant_sel[0])
    else $error("Idle diversity second antenna level wrong");
  chk_div_beacon: assert property (
    ant_sel[2] |-> div_beacon_mode == (ant_sel >= 3'h6))
    else $error("Beacon variant flag wrong");
  chk_div_enable: assert property (
    !rx_state |-> !div_enable)
    else $error("Diversity enabled outside receive");
  chk_single_pkt: assert property (
    pkt_valid && !fifo_mode_multi_pkt |-> rxon_auto_clr && rx_leave_req)
    else $error("Single packet did not end receive");
  chk_multi_pkt: assert property (
    fifo_mode_multi_pkt |-> !rx_leave_req)
    else $error("Multi packet mode left receive");
  chk_mpk_write: assert property (
    wr_func |=> fifo_mode_multi_pkt == $past(reg_wdata[RFC_MPK_BIT]))
    else $error("Multi packet bit not stored");
  chk_xtal_write: assert property (
    reg_wr_en && reg_addr == RFC_ADDR_XTAL_LOAD |=>
      xtal_coarse_shift == $past(reg_wdata[7])
      && xtal_load_code == $past(reg_wdata[6:0]))
    else $error("Crystal load fields not stored");
  // A read in the cycle of a write returns the old value, so skip those.
  chk_xtal_rdata: assert property (
    reg_rd_en && !reg_wr_en && reg_addr == RFC_ADDR_XTAL_LOAD |=>
      reg_rdata == {xtal_coarse_shift, xtal_load_code})
    else $error("Crystal load read back differs");
  chk_ldm_write: assert property (
    wr_func |=> low_duty_enable == $past(reg_wdata[RFC_LDM_BIT]))
    else $error("Low duty enable not stored");
  chk_func_rdata: assert property (
    reg_rd_en && !reg_wr_en && reg_addr == RFC_ADDR_RX_FUNC |=>
      reg_rdata[RFC_MPK_BIT] == fifo_mode_multi_pkt
      && reg_rdata[RFC_LDM_BIT] == low_duty_enable)
    else $error("Function register read back differs");
endmodule : rfc_regs
`default_nettype wire

// *** rfc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 7'h00;
    wdata = 8'h00;
  end
  // Each write to 0x08 is a whole setting, so low duty never goes alone.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
    // Released data is inverted so a stale bus value cannot look valid.
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'h1;
    @(negedge clk);
    rd_en = 1'h0;
    d = rdata;
  endtask : rd
endmodule : rfc_host
`default_nettype wire

// *** rfc_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_regs_tb_top;
  import rfc_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic rx = 1'h0;
  logic pv = 1'h0;
  logic da = 1'h0;
  logic db = 1'h0;
  logic we, re, aa, ab, fm, lv, ac, ld, de, bm, fc, sh;
  logic [6:0] ad, xc;
  logic [7:0] wd, rdt, v, d;
  int n_fail = 0;
  int checked = 0;
  int seed = 83;
  int n;
  rfc_host rfc_host_i (.clk(clk), .wr_en(we), .rd_en(re), .addr(ad),
    .wdata(wd), .rdata(rdt));
  rfc_regs rfc_regs_i (.clk(clk), .rst_n(rst_n), .reg_wr_en(we),
    .reg_rd_en(re), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdt),
    .rx_state(rx), .pkt_valid(pv), .div_ant_a(da), .div_ant_b(db),
    .antenna_select_out_a(aa), .antenna_select_out_b(ab),
    .fifo_mode_multi_pkt(fm), .rx_leave_req(lv), .rxon_auto_clr(ac),
    .low_duty_enable(ld), .div_enable(de), .div_beacon_mode(bm),
    .rx_fifo_clear(fc), .xtal_load_code(xc), .xtal_coarse_shift(sh));
  initial forever #50 clk = ~clk;
  function automatic logic [1:0] ant(input logic [2:0] s, input logic r);
    if (!r) return s[2] ? {2{s[0]}} : {2{s[1]}};
    return s[2] ? {da, db} : {s[0], !s[0]};
  endfunction : ant
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    rfc_host_i.rd(7'h08, v);
    chk("func_rst", v, RFC_RX_FUNC_RST);
    for (int i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      d = {i[2:0], v[4:0]};
      rfc_host_i.wr(7'h08, d);
      rfc_host_i.rd(7'h08, v);
      chk("func", v, d & RFC_RX_FUNC_WMASK);
      chk("mpk_ldm", {6'h00, fm, ld}, {6'h00, d[4], d[2]});
      v = 8'($random(seed));
      {rx, pv, da, db} = v[3:0];
      #1;
      chk("ant", {6'h00, aa, ab}, {6'h00, ant(d[7:5], rx)});
      chk("div", {6'h00, de, bm}, {6'h00, rx & d[7], d[7] & d[6]});
      chk("leave", {6'h00, lv, ac}, {6'h00, {2{pv & !d[4]}}});
      pv = 1'h0;
      @(negedge clk);
      rx = !rx;
      #1;
      chk("ant_rx", {6'h00, aa, ab}, {6'h00, ant(d[7:5], rx)});
      d = 8'($random(seed));
      rfc_host_i.wr(7'h09, d);
      rfc_host_i.rd(7'h09, v);
      chk("xtal", v, d);
      chk("xtal_f", {sh, xc}, d);
    end
    rfc_host_i.wr(7'h08, 8'h02);
    rfc_host_i.wr(7'h08, 8'h02);
    rfc_host_i.wr(7'h08, 8'h00);
    n = 0;
    repeat (4) begin
      n += int'(fc === 1'h1);
      @(negedge clk);
    end
    chk("fclr", 8'(n), 8'h01);
    rfc_host_i.wr(7'h0A, 8'hFF);
    rfc_host_i.rd(7'h0A, v);
    chk("unmapped", v, 8'h00);
    rfc_host_i.rd(7'h09, v);
    chk("xtal_keep", v, d);
    rfc_host_i.wr(7'h08, 8'h02);
    @(negedge clk);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    rfc_host_i.rd(7'h08, v);
    chk("func_rst2", v, RFC_RX_FUNC_RST);
    rfc_host_i.rd(7'h09, v);
    chk("xtal_rst2", v, RFC_XTAL_LOAD_RST);
    rfc_host_i.wr(7'h08, 8'h00);
    chk("fclr_rst", {7'h00, fc}, 8'h00);
    end_sim();
  end
endmodule : rfc_regs_tb_top
`default_nettype wire
